// ==== hdl/upf_port.sv ====
// Parallel FIFO port: pin handshake, flush/wake, power and APB view
//
// Notes on behaviour
// - Hold high when full or storing byte.
// - Read-available low while receive data waits.
// - Baud-rate commands are accepted and ignored.
// - Power-ok high in suspend or power-off.
// - Optional weak pulldown while power-ok high.
// - Flush strobe in suspend requests resume.
// - Flush strobe otherwise marks all data sendable.
// - Programmable 1-255 ms transmit flush timeout.
// - Isochronous mode follows configuration bit.
// - Transmit 384 bytes, receive 128 bytes.
// - Power-on reset and external reset input.
// - Reset output follows power-on reset; the external reset input also pulls it low.
// - Write strobe stores, read strobe removes.
// - Controller runs from the single system clock.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "upf_defs.svh"
module upf_port
    import upf_pkg::*;
#(
    parameter int TX_DEPTH = `UPF_TX_DEPTH,
    parameter int RX_DEPTH = `UPF_RX_DEPTH,
    parameter int MS_CYCLES = `UPF_MS_NS / `UPF_CLK_NS,
    parameter int RELEASE_CYCLES = `UPF_RELEASE_MS * (`UPF_MS_NS / `UPF_CLK_NS)
) (
    input wire logic mclk, // system clock
    input wire logic rst, // power-on reset, high
    input wire logic ce, // clock enable
    input wire logic ext_reset_n, // external reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [7:0] dataIn, // data bus in
    output logic [7:0] dataOut, // data bus out
    output logic dataOe_n, // bus drive, low
    input wire logic write_strobe_n, // write strobe, low
    input wire logic read_strobe_n, // read strobe, low
    input wire logic flush_wake_strobe_n, // flush/wake, low
    output logic write_hold_n, // write hold
    output logic read_avail_n, // data waiting, low
    output logic power_ok_n, // power switch, low on
    output logic pulldownEn, // weak pulldown of bus
    output logic resumeReq, // resume request
    output logic flushReq, // send all on next IN
    output logic isoMode, // isochronous transfers
    output logic reset_out_n // reset out, low
);
    localparam int TCW = $clog2(TX_DEPTH+1);
    localparam int RCW = $clog2(RX_DEPTH+1);

    generate
        if (TX_DEPTH < 2 || TX_DEPTH > 65535 || RX_DEPTH < 2 ||
                RX_DEPTH > 255 || MS_CYCLES < 1 || RELEASE_CYCLES < 1)
        begin : g_bad
            $error("upf_port: parameter out of range");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Reset and strobe edges
    // ---------------------------------------------------------------
    logic sysRst, wrFall, rdFall, flFall;
    upf_strobe_t prev_r;

    assign sysRst = rst || !ext_reset_n;

    always_ff @(posedge mclk) begin
        if (sysRst) begin
            prev_r <= '1;
        end else if (ce) begin
            prev_r <= '{write_strobe_n, read_strobe_n, flush_wake_strobe_n};
        end
    end

    assign wrFall = prev_r.wr && !write_strobe_n;
    assign rdFall = prev_r.rd && !read_strobe_n;
    assign flFall = prev_r.fl && !flush_wake_strobe_n;

    // ---------------------------------------------------------------
    // Buffers
    // ---------------------------------------------------------------
    logic txPush, txPop, txFull, txEmpty;
    logic rxPush, rxPop, rxFull, rxEmpty;
    logic [7:0] txHead, rxHead;
    logic [TCW-1:0] txCount;
    logic [RCW-1:0] rxCount;
    logic write_hold_n_r, read_avail_n_r;

    // A strobe while held is dropped, so a full buffer is never overrun
    assign txPush = wrFall && !write_hold_n_r;
    assign rxPop = rdFall && !read_avail_n_r;

    upf_fifo #(.W(8), .DEPTH(TX_DEPTH)) u_tx (
        .clk(mclk),
        .rst(sysRst),
        .ce(ce),
        .push(txPush),
        .din(dataIn),
        .pop(txPop),
        .dout(txHead),
        .count(txCount),
        .full(txFull),
        .empty(txEmpty)
    );

    upf_fifo #(.W(8), .DEPTH(RX_DEPTH)) u_rx (
        .clk(mclk),
        .rst(sysRst),
        .ce(ce),
        .push(rxPush),
        .din(pwdata[7:0]),
        .pop(rxPop),
        .dout(rxHead),
        .count(rxCount),
        .full(rxFull),
        .empty(rxEmpty)
    );

    // ---------------------------------------------------------------
    // Pin handshake
    // ---------------------------------------------------------------
    logic [7:0] dataOut_r;
    logic dataOe_n_r;

    // Hold stays high for the cycle after a store, so the partner can
    // not strobe again before the count has moved
    always_ff @(posedge mclk) begin
        if (sysRst) begin
            write_hold_n_r <= 1'b1;
        end else if (ce) begin
            write_hold_n_r <= txFull || txPush;
        end
    end

    // Taking the last byte raises the flag at once, not a cycle late
    always_ff @(posedge mclk) begin
        if (sysRst) begin
            read_avail_n_r <= 1'b1;
        end else if (ce) begin
            read_avail_n_r <= rxEmpty || (rxPop && !rxPush &&
                rxCount == RCW'(1));
        end
    end

    always_ff @(posedge mclk) begin
        if (sysRst) begin
            dataOut_r <= 8'h00;
            dataOe_n_r <= 1'b1;
        end else if (ce) begin
            if (rxPop) begin
                dataOut_r <= rxHead;
            end
            dataOe_n_r <= read_strobe_n;
        end
    end

    // ---------------------------------------------------------------
    // APB registers
    // ---------------------------------------------------------------
    upf_ctrl_t ctrl_r;
    logic [31:0] prdata_r, status;
    logic pready_r, pslverr_r, flushPend_r, resumeReq_r;
    logic apbSetup, apbDone;

    assign apbSetup = psel && !penable;
    assign apbDone = psel && penable && pready_r;
    assign txPop = apbDone && !pwrite && paddr == `UPF_OFS_TXDATA;
    assign rxPush = apbDone && pwrite && paddr == `UPF_OFS_RXDATA;

    always_comb begin
        status = 32'h0000_0000;
        status[`UPF_ST_TXCNT +: 16] = 16'(txCount);
        status[`UPF_ST_RXCNT +: 8] = 8'(rxCount);
        status[`UPF_ST_FLUSH] = flushPend_r;
        status[`UPF_ST_RESUME] = resumeReq_r;
        status[`UPF_ST_TXEMPTY] = txEmpty;
        status[`UPF_ST_RXFULL] = rxFull;
        status[`UPF_ST_SUSP] = ctrl_r.suspend;
    end

    // Answer is prepared in the setup cycle so the access needs no wait
    always_ff @(posedge mclk) begin
        if (sysRst) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end else if (ce) begin
            pready_r <= 1'b1;
            if (apbSetup) begin
                prdata_r <= 32'h0000_0000;
                pslverr_r <= 1'b0;
                unique case (paddr)
                    `UPF_OFS_CTRL: begin
                        prdata_r <= 32'(ctrl_r);
                    end
                    `UPF_OFS_STATUS: begin
                        prdata_r <= status;
                    end
                    `UPF_OFS_TXDATA: begin
                        prdata_r <= {24'h000000, txHead};
                        pslverr_r <= pwrite || txEmpty;
                    end
                    `UPF_OFS_RXDATA: begin
                        pslverr_r <= !pwrite || rxFull;
                    end
                    `UPF_OFS_BAUD: begin
                        pslverr_r <= 1'b0;
                    end
                    default: begin
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Rate commands land on the rate offset and change nothing
    always_ff @(posedge mclk) begin
        if (sysRst) begin
            ctrl_r <= `UPF_CTRL_RST;
        end else if (ce && apbDone && pwrite && paddr == `UPF_OFS_CTRL) begin
            ctrl_r <= pwdata[$bits(upf_ctrl_t)-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Flush timeout
    // ---------------------------------------------------------------
    logic [31:0] msCnt_r;
    logic [7:0] toCnt_r, toLimit;
    logic txActive, msTick, timeoutHit;

    // A zero setting is served as the shortest timeout
    assign toLimit = (ctrl_r.timeoutMs == 8'h00) ? `UPF_TO_MIN_MS :
        ctrl_r.timeoutMs;
    assign txActive = !txEmpty && !flushPend_r && !txPush;
    assign msTick = txActive && msCnt_r == 32'(MS_CYCLES - 1);
    assign timeoutHit = msTick &&
        ({1'b0, toCnt_r} + 9'h001 >= {1'b0, toLimit});

    // Any new byte restarts the wait, so only idle data is flushed
    always_ff @(posedge mclk) begin
        if (sysRst) begin
            msCnt_r <= 32'h0000_0000;
            toCnt_r <= 8'h00;
        end else if (ce) begin
            if (!txActive || msTick) begin
                msCnt_r <= 32'h0000_0000;
            end else begin
                msCnt_r <= msCnt_r + 32'h0000_0001;
            end
            if (!txActive || timeoutHit) begin
                toCnt_r <= 8'h00;
            end else if (msTick) begin
                toCnt_r <= toCnt_r + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Flush, wake and power
    // ---------------------------------------------------------------
    logic stW1c, pulldown_r, power_ok_n_r, reset_out_n_r;
    logic [31:0] releaseCnt_r;

    assign stW1c = apbDone && pwrite && paddr == `UPF_OFS_STATUS;

    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge mclk) begin
        if (sysRst) begin
            flushPend_r <= 1'b0;
            resumeReq_r <= 1'b0;
        end else if (ce) begin
            if ((flFall && !ctrl_r.suspend) || timeoutHit) begin
                flushPend_r <= 1'b1;
            end else if (stW1c && pwdata[`UPF_ST_FLUSH]) begin
                flushPend_r <= 1'b0;
            end
            if (flFall && ctrl_r.suspend && ctrl_r.wakeEn) begin
                resumeReq_r <= 1'b1;
            end else if (stW1c && pwdata[`UPF_ST_RESUME]) begin
                resumeReq_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sysRst) begin
            power_ok_n_r <= 1'b1;
            pulldown_r <= 1'b0;
        end else if (ce) begin
            power_ok_n_r <= ctrl_r.suspend || ctrl_r.powerOff;
            pulldown_r <= ctrl_r.pullEn && power_ok_n_r;
        end
    end

    // Reset output is released only after a settling delay
    always_ff @(posedge mclk) begin
        if (sysRst) begin
            releaseCnt_r <= 32'h0000_0000;
            reset_out_n_r <= 1'b0;
        end else if (ce && !reset_out_n_r) begin
            releaseCnt_r <= releaseCnt_r + 32'h0000_0001;
            reset_out_n_r <= (releaseCnt_r == 32'(RELEASE_CYCLES - 1));
        end
    end

    // Single clock domain: mclk stands in for the 12 MHz reference
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dataOut = dataOut_r;
    assign dataOe_n = dataOe_n_r;
    assign write_hold_n = write_hold_n_r;
    assign read_avail_n = read_avail_n_r;
    assign power_ok_n = power_ok_n_r;
    assign pulldownEn = pulldown_r;
    assign resumeReq = resumeReq_r;
    assign flushReq = flushPend_r;
    assign isoMode = ctrl_r.isoEn;
    assign reset_out_n = reset_out_n_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    AST_HOLD_FULL: assert property (@(posedge mclk) disable iff (sysRst)
        ce && txFull |=> write_hold_n)
        else $error("write hold low while transmit buffer full");
    AST_HOLD_STORE: assert property (@(posedge mclk) disable iff (sysRst)
        ce && wrFall && write_hold_n |=> $stable(txCount) || $past(txPop))
        else $error("held write changed transmit count");
    AST_RXF: assert property (@(posedge mclk) disable iff (sysRst)
        ce && !rxEmpty && !rxPop |=> !read_avail_n)
        else $error("read-available high with data waiting");
    AST_RD_EMPTY: assert property (@(posedge mclk) disable iff (sysRst)
        ce && rdFall && read_avail_n && !rxPush |=> $stable(rxCount))
        else $error("read while empty changed receive buffer");
    AST_PWR: assert property (@(posedge mclk) disable iff (sysRst)
        ce && !ctrl_r.suspend && !ctrl_r.powerOff |=> !power_ok_n)
        else $error("power-ok high outside suspend");
    AST_PULL: assert property (@(posedge mclk) disable iff (sysRst)
        pulldownEn |-> $past(power_ok_n) && $past(ctrl_r.pullEn))
        else $error("pulldown without power-off and option");
    AST_WAKE: assert property (@(posedge mclk) disable iff (sysRst)
        ce && flFall && ctrl_r.suspend && ctrl_r.wakeEn |=> resumeReq)
        else $error("wake strobe gave no resume request");
    AST_FLUSH: assert property (@(posedge mclk) disable iff (sysRst)
        ce && flFall && !ctrl_r.suspend |=> flushReq ##1 flushReq || !ce ||
        $past(stW1c))
        else $error("flush strobe not recorded");
    AST_TIMEOUT: assert property (@(posedge mclk) disable iff (sysRst)
        ce && timeoutHit |=> flushReq && toCnt_r == 8'h00)
        else $error("timeout did not raise flush");
    AST_RST_OUT: assert property (@(posedge mclk)
        sysRst |=> !reset_out_n)
        else $error("reset out high during reset");
endmodule : upf_port

// ==== hdl/upf_defs.svh ====
// Offsets, field positions, reset values and timing figures of the FIFO port
`ifndef UPF_DEFS_SVH
`define UPF_DEFS_SVH
`define UPF_TX_DEPTH 384
`define UPF_RX_DEPTH 128
`define UPF_CLK_NS 10
`define UPF_MS_NS 1000000
`define UPF_RELEASE_MS 5
`define UPF_TO_MIN_MS 8'h01
`define UPF_OFS_CTRL 8'h00
`define UPF_OFS_STATUS 8'h04
`define UPF_OFS_TXDATA 8'h08
`define UPF_OFS_RXDATA 8'h0C
`define UPF_OFS_BAUD 8'h10
`define UPF_CTRL_RST 13'h0010
`define UPF_ST_TXCNT 0
`define UPF_ST_RXCNT 16
`define UPF_ST_FLUSH 24
`define UPF_ST_RESUME 25
`define UPF_ST_TXEMPTY 26
`define UPF_ST_RXFULL 27
`define UPF_ST_SUSP 28
`endif

// ==== hdl/upf_pkg.sv ====
// Types shared by the FIFO port modules
package upf_pkg;
    // Control register, timeout in the low byte
    typedef struct packed {
        logic powerOff;
        logic suspend;
        logic pullEn;
        logic wakeEn;
        logic isoEn;
        logic [7:0] timeoutMs;
    } upf_ctrl_t;

    // Previous levels of the three strobe pins
    typedef struct packed {
        logic wr;
        logic rd;
        logic fl;
    } upf_strobe_t;
endpackage : upf_pkg

// ==== hdl/upf_fifo.sv ====
// Parameterised synchronous byte FIFO used for both buffers
`timescale 1ns/1ps
module upf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset, high
    input wire logic ce, // clock enable
    input wire logic push, // store din
    input wire logic [W-1:0] din, // data in
    input wire logic pop, // drop head
    output logic [W-1:0] dout, // head word
    output logic [$clog2(DEPTH+1)-1:0] count, // words held
    output logic full, // no room
    output logic empty // nothing held
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    generate
        if (DEPTH < 2) begin : g_bad
            $error("upf_fifo: DEPTH must be at least 2");
        end
    endgenerate

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] rdPtr_r;
    logic [CW-1:0] count_r;
    logic doPush;
    logic doPop;

    assign doPush = push && !full;
    assign doPop = pop && !empty;
    assign full = (count_r == CW'(DEPTH));
    assign empty = (count_r == '0);
    assign dout = mem[rdPtr_r];
    assign count = count_r;

    always_ff @(posedge clk) begin
        if (ce && doPush) begin
            mem[wrPtr_r] <= din;
        end
    end

    // Depth need not be a power of two, so pointers wrap explicitly
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (ce) begin
            if (doPush) begin
                wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            if (doPush && !doPop) begin
                count_r <= count_r + 1'b1;
            end else if (doPop && !doPush) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : upf_fifo

// ==== dv/upf_mcu.sv ====
// Model of the external logic that drives the FIFO pins
`timescale 1ns/1ps
module upf_mcu (
    input wire logic mclk, // system clock
    input wire logic [7:0] dataOut, // byte from device
    input wire logic dataOe_n, // device drives bus
    input wire logic write_hold_n, // write hold
    input wire logic read_avail_n, // data waiting
    output logic [7:0] dataIn, // byte to device
    output logic write_strobe_n, // write strobe
    output logic read_strobe_n, // read strobe
    output logic flush_wake_strobe_n // flush/wake strobe
);
    initial begin
        dataIn = 8'h5A;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        flush_wake_strobe_n = 1'b1;
    end

    // Blind strobes skip the handshake, for refusal scenarios only
    task automatic wr(input logic [7:0] d, input bit blind, output bit ok);
        int n;
        n = 0;
        while (!blind && write_hold_n !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        ok = n < 50;
        dataIn <= d;
        write_strobe_n <= 1'b0;
        @(posedge mclk);
        write_strobe_n <= 1'b1;
        dataIn <= ~d; // Released bus must not keep the old byte
        @(posedge mclk);
    endtask : wr

    task automatic rd(input bit blind, output logic [7:0] b,
                      output logic oe, output bit ok);
        int n;
        n = 0;
        while (!blind && read_avail_n !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        ok = n < 50;
        read_strobe_n <= 1'b0;
        @(posedge mclk);
        read_strobe_n <= 1'b1;
        @(posedge mclk);
        b = dataOut;
        oe = dataOe_n;
    endtask : rd

    task automatic fl;
        flush_wake_strobe_n <= 1'b0;
        @(posedge mclk);
        flush_wake_strobe_n <= 1'b1;
        @(posedge mclk);
    endtask : fl
endmodule : upf_mcu

// ==== dv/testbench.sv ====
// Self-checking bench for the parallel FIFO port
`timescale 1ns/1ps
module testbench;
    localparam int MS = 10;
    localparam int REL_CYCLES = 4;
    logic mclk, rst, ext_reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, dataIn, dataOut, b;
    logic [31:0] pwdata, prdata, rdata;
    logic dataOe_n, write_strobe_n, read_strobe_n, flush_wake_strobe_n;
    logic write_hold_n, read_avail_n, power_ok_n, pulldownEn, resumeReq;
    logic flushReq, isoMode, reset_out_n, serr, oe, ce;
    bit ok;
    int errors = 0;
    int comparisons = 0;

    upf_port #(.MS_CYCLES(MS), .RELEASE_CYCLES(REL_CYCLES)) uut (
        .mclk, .rst, .ce, .ext_reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .dataIn, .dataOut,
        .dataOe_n, .write_strobe_n, .read_strobe_n, .flush_wake_strobe_n,
        .write_hold_n, .read_avail_n, .power_ok_n, .pulldownEn,
        .resumeReq, .flushReq, .isoMode, .reset_out_n
    );
    upf_mcu mcu (
        .mclk, .dataOut, .dataOe_n, .write_hold_n, .read_avail_n, .dataIn,
        .write_strobe_n, .read_strobe_n, .flush_wake_strobe_n
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ----------
    // Helpers
    // ----------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic need(input bit good);
        if (!good) begin
            errors++;
            $display("ERROR %0t: wait timed out", $time);
            test_done();
        end
    endtask : need

    // One APB transfer; the request holds until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        need(pready === 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ----------
    // Scenarios
    // ----------
    task automatic s_reset;
        int n;
        chk({write_hold_n, read_avail_n, reset_out_n}, 3'b110);
        n = 0;
        while (reset_out_n !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        chk(n >= REL_CYCLES && n <= REL_CYCLES + 2, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdata, 32'h0000_0010);
        mcu.wr(8'h42, 1'b0, ok);
        need(ok);
        ext_reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({write_hold_n, reset_out_n}, 2'b10);
        ext_reset_n <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        chk(rdata[15:0], 16'h0000);
    endtask : s_reset

    task automatic s_write;
        mcu.wr(8'h3C, 1'b0, ok);
        need(ok);
        chk(write_hold_n, 1'b1);
        mcu.wr(8'hC3, 1'b0, ok);
        need(ok);
        apb(1'b0, 8'h04, 32'h0);
        chk(rdata[15:0], 16'h0002);
        apb(1'b0, 8'h08, 32'h0);
        chk(rdata, 32'h0000_003C);
        apb(1'b0, 8'h08, 32'h0);
        chk(rdata, 32'h0000_00C3);
    endtask : s_write

    // Fill to the brim, strobe once more, then drain in order
    task automatic s_full;
        for (int i = 0; i < 384; i++) begin
            mcu.wr(i[7:0], 1'b0, ok);
            need(ok);
        end
        repeat (2) @(posedge mclk);
        chk(write_hold_n, 1'b1);
        mcu.wr(8'hEE, 1'b1, ok);
        apb(1'b0, 8'h04, 32'h0);
        chk(rdata[15:0], 16'h0180);
        for (int i = 0; i < 384; i++) begin
            apb(1'b0, 8'h08, 32'h0);
            chk(rdata, {24'h0, i[7:0]});
        end
        repeat (2) @(posedge mclk);
        chk(write_hold_n, 1'b0);
    endtask : s_full

    task automatic s_rx;
        int n;
        apb(1'b1, 8'h0C, 32'h0000_005A);
        apb(1'b1, 8'h0C, 32'h0000_00A5);
        @(posedge mclk);
        chk(read_avail_n, 1'b0);
        mcu.rd(1'b0, b, oe, ok);
        need(ok);
        chk({oe, b}, 9'h05A);
        mcu.rd(1'b0, b, oe, ok);
        need(ok);
        chk({read_avail_n, b}, 9'h1A5);
        mcu.rd(1'b1, b, oe, ok);
        chk(dataOut, 8'hA5);
        for (int i = 0; i < 129; i++) begin
            apb(1'b1, 8'h0C, {24'h0, i[7:0]});
            chk(serr, i == 128);
        end
        apb(1'b0, 8'h04, 32'h0);
        chk({rdata[27:26], rdata[23:16]}, 10'h380);
        n = 0;
        while (read_avail_n === 1'b0 && n < 200) begin
            mcu.rd(1'b0, b, oe, ok);
            chk(b, n[7:0]);
            n++;
        end
        chk(n, 128);
    endtask : s_rx

    task automatic s_flush;
        apb(1'b1, 8'h04, 32'h0300_0000);
        mcu.fl();
        chk({resumeReq, flushReq}, 2'b01);
        apb(1'b1, 8'h00, 32'h0000_0E10);
        repeat (3) @(posedge mclk);
        chk({power_ok_n, pulldownEn}, 2'b11);
        apb(1'b1, 8'h04, 32'h0300_0000);
        mcu.fl();
        chk({resumeReq, flushReq}, 2'b10);
        apb(1'b1, 8'h00, 32'h0000_0810);
        apb(1'b1, 8'h04, 32'h0300_0000);
        mcu.fl();
        chk({power_ok_n, resumeReq, flushReq}, 3'b100);
        apb(1'b1, 8'h00, 32'h0000_1110);
        repeat (3) @(posedge mclk);
        chk({power_ok_n, pulldownEn, isoMode}, 3'b101);
        apb(1'b1, 8'h00, 32'h0000_0010);
        repeat (3) @(posedge mclk);
        chk({power_ok_n, pulldownEn, isoMode}, 3'b000);
    endtask : s_flush

    // Zero, shortest and longest flush timeout, timed from the last write
    task automatic s_timeout;
        int n;
        int ms;
        int t[3] = '{0, 1, 255};
        foreach (t[k]) begin
            ms = (t[k] == 0) ? 1 : t[k];
            apb(1'b1, 8'h00, {24'h0, t[k][7:0]});
            apb(1'b1, 8'h04, 32'h0100_0000);
            mcu.wr(8'h77, 1'b0, ok);
            need(ok);
            n = 0;
            while (flushReq !== 1'b1 && n < 3000) begin
                @(posedge mclk);
                n++;
            end
            chk(n >= ms * MS - 3 && n <= ms * MS + 3, 1'b1);
            apb(1'b0, 8'h08, 32'h0);
        end
    endtask : s_timeout

    task automatic s_misc;
        apb(1'b1, 8'h10, 32'h0000_1234);
        chk(serr, 1'b0);
        apb(1'b0, 8'h10, 32'h0);
        chk(rdata, 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdata, 32'h0000_00FF);
        apb(1'b1, 8'h14, 32'h0000_0001);
        chk(serr, 1'b1);
    endtask : s_misc

    // A strobe while frozen must leave no trace once enabled again
    task automatic s_freeze;
        ce <= 1'b0;
        mcu.wr(8'h11, 1'b0, ok);
        need(ok);
        ce <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        chk(rdata[15:0], 16'h0000);
    endtask : s_freeze

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        ext_reset_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        s_reset();
        s_write();
        s_full();
        s_rx();
        s_flush();
        s_timeout();
        s_misc();
        s_freeze();
        test_done();
    end
endmodule : testbench
